// >>> hdl/bbd_defs.svh
`ifndef BBD_DEFS_SVH
`define BBD_DEFS_SVH
`define BBD_REG_CTRL 8'h00
`define BBD_REG_STAT 8'h04
`define BBD_REG_LAST 8'h08
`define BBD_REG_CNT 8'h0c
`define BBD_CTRL_HOLD 0
`define BBD_CTRL_PSA 1
`define BBD_CTRL_BANK 11:8
`define BBD_RESP_OKAY 2'h0
`define BBD_RESP_SLVERR 2'h2
`define BBD_FL_ALL 5'h1f
`define BBD_FL_ZN 5'h14
`define BBD_FL_CZN 5'h15
`define BBD_FL_NONE 5'h00
`define BBD_PFX_2ND 4'hf
`define BBD_PFX_FF 4'hc
`define BBD_OPC_AJUMP 8'hef
`define BBD_CYC_ONE 2'h1
`define BBD_CYC_TWO 2'h2
`define BBD_BANK_LO 4'h0
`define BBD_BANK_HI 4'hf
`endif

// >>> hdl/bbd_pkg.sv
package bbd_pkg;
  typedef enum logic [1:0] {ST_ONE, ST_SECOND, ST_FLUSH} bbd_st_t;
  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADDC, OP_AND, OP_OR, OP_XOR, OP_COM, OP_DEC,
    OP_INC, OP_DECSZ, OP_INCSZ, OP_DECSNZ, OP_INCSNZ, OP_CPEQ, OP_CPGT,
    OP_CPLT, OP_TSTZ, OP_RLC, OP_RRC, OP_RL, OP_RR, OP_MOVE, OP_SUB,
    OP_SUBB, OP_SUBFB, OP_MUL, OP_FFMOVE, OP_AJUMP, OP_CALL,
    OP_UBRANCH, OP_CBRANCH, OP_BIT, OP_OTHER
  } bbd_op_t;
  typedef struct packed {
    logic        vld;
    logic        nop;
    bbd_op_t     op;
    logic        to_file;
    logic        use_bank;
    logic [11:0] faddr;
    logic [11:0] daddr;
    logic [2:0]  bitpos;
    logic [7:0]  imm;
    logic [19:0] target;
    logic        fast;
    logic        shadow;
    logic [15:0] offset;
    logic [4:0]  flags;
    logic [1:0]  cycles;
    logic        can_skip;
    logic        pc_chg;
    logic        rmw_pins;
    logic        presc_clr;
  } bbd_dec_t;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } bbd_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bbd_axi_rsp_t;
  typedef struct packed {
    bbd_st_t      st;
    bbd_op_t      pend;
    logic [11:0]  src;
    logic [7:0]   lo;
    logic         fast;
    bbd_dec_t     dec;
    logic         hold;
    logic         psa;
    logic [3:0]   bank;
    logic [15:0]  last;
    logic [15:0]  cnt;
    logic         aw_got;
    logic [7:0]   awa;
    logic         w_got;
    logic [31:0]  wd;
    logic [3:0]   ws;
    bbd_axi_rsp_t rsp;
  } bbd_state_t;
endpackage

// >>> hdl/bbd_decoder.sv
`timescale 1ns/1ps
`include "bbd_defs.svh"
module bbd_decoder #(
  parameter logic [7:0]  ACCESS_SPLIT = 8'h80,
  parameter logic [11:0] PORT_LO      = 12'hf80,
  parameter logic [11:0] PORT_HI      = 12'hf8f,
  parameter logic [11:0] TIMER_ADDR   = 12'hfc0
) (
  input  logic                  sys_clk,
  input  logic                  rst_b,
  input  logic                  insn_valid,
  input  logic [15:0]           insn_word,
  input  logic                  cond_taken,
  input  bbd_pkg::bbd_axi_req_t axi_req,
  output bbd_pkg::bbd_axi_rsp_t axi_rsp,
  output bbd_pkg::bbd_dec_t     dec_o
);

  bbd_pkg::bbd_state_t s_q;
  bbd_pkg::bbd_state_t s_d;
  bbd_pkg::bbd_dec_t   w;
  logic                take;
  logic                nopw;

  function automatic bbd_pkg::bbd_dec_t dec_word(
    input logic [15:0] iw,
    input logic [3:0]  bank,
    input logic        psa
  );
    bbd_pkg::bbd_dec_t r;
    logic              byte_op;
    r = '0;
    byte_op = 1'b1;
    r.vld = 1'b1;
    r.cycles = `BBD_CYC_ONE;
    r.bitpos = iw[11:9];
    r.imm = iw[7:0];
    r.use_bank = iw[8];
    // Access bank splits between bank zero and the top bank
    if (iw[8]) begin
      r.faddr = {bank, iw[7:0]};
    end else if (iw[7:0] >= ACCESS_SPLIT) begin
      r.faddr = {`BBD_BANK_HI, iw[7:0]};
    end else begin
      r.faddr = {`BBD_BANK_LO, iw[7:0]};
    end
    r.to_file = iw[9];
    r.op = bbd_pkg::OP_OTHER;
    casez (iw[15:8])
      8'b0010_01??: begin
        r.op = bbd_pkg::OP_ADD;
        r.flags = `BBD_FL_ALL;
      end
      8'b0010_00??: begin
        r.op = bbd_pkg::OP_ADDC;
        r.flags = `BBD_FL_ALL;
      end
      8'b0001_01??: begin
        r.op = bbd_pkg::OP_AND;
        r.flags = `BBD_FL_ZN;
      end
      8'b0001_00??: begin
        r.op = bbd_pkg::OP_OR;
        r.flags = `BBD_FL_ZN;
      end
      8'b0001_10??: begin
        r.op = bbd_pkg::OP_XOR;
        r.flags = `BBD_FL_ZN;
      end
      8'b0001_11??: begin
        r.op = bbd_pkg::OP_COM;
        r.flags = `BBD_FL_ZN;
      end
      8'b0000_01??: begin
        r.op = bbd_pkg::OP_DEC;
        r.flags = `BBD_FL_ALL;
      end
      8'b0010_10??: begin
        r.op = bbd_pkg::OP_INC;
        r.flags = `BBD_FL_ALL;
      end
      8'b0010_11??: begin
        r.op = bbd_pkg::OP_DECSZ;
        r.can_skip = 1'b1;
      end
      8'b0011_11??: begin
        r.op = bbd_pkg::OP_INCSZ;
        r.can_skip = 1'b1;
      end
      8'b0100_11??: begin
        r.op = bbd_pkg::OP_DECSNZ;
        r.can_skip = 1'b1;
      end
      8'b0100_10??: begin
        r.op = bbd_pkg::OP_INCSNZ;
        r.can_skip = 1'b1;
      end
      8'b0110_001?: r.op = bbd_pkg::OP_CPEQ;
      8'b0110_010?: r.op = bbd_pkg::OP_CPGT;
      8'b0110_000?: r.op = bbd_pkg::OP_CPLT;
      8'b0110_011?: r.op = bbd_pkg::OP_TSTZ;
      8'b0011_01??: begin
        r.op = bbd_pkg::OP_RLC;
        r.flags = `BBD_FL_CZN;
      end
      8'b0011_00??: begin
        r.op = bbd_pkg::OP_RRC;
        r.flags = `BBD_FL_CZN;
      end
      8'b0100_01??: begin
        r.op = bbd_pkg::OP_RL;
        r.flags = `BBD_FL_ZN;
      end
      8'b0100_00??: begin
        r.op = bbd_pkg::OP_RR;
        r.flags = `BBD_FL_ZN;
      end
      8'b0101_00??: begin
        r.op = bbd_pkg::OP_MOVE;
        r.flags = `BBD_FL_ZN;
      end
      8'b0101_11??: begin
        r.op = bbd_pkg::OP_SUB;
        r.flags = `BBD_FL_ALL;
      end
      8'b0101_10??: begin
        r.op = bbd_pkg::OP_SUBB;
        r.flags = `BBD_FL_ALL;
      end
      8'b0101_01??: begin
        r.op = bbd_pkg::OP_SUBFB;
        r.flags = `BBD_FL_ALL;
      end
      8'b0000_001?: r.op = bbd_pkg::OP_MUL;
      default: byte_op = 1'b0;
    endcase
    casez (iw[15:8])
      8'b1100_????: r.op = bbd_pkg::OP_FFMOVE;
      `BBD_OPC_AJUMP: r.op = bbd_pkg::OP_AJUMP;
      8'b1110_110?: r.op = bbd_pkg::OP_CALL;
      8'b1101_0???: begin
        r.op = bbd_pkg::OP_UBRANCH;
        r.offset = {{5{iw[10]}}, iw[10:0]};
        r.cycles = `BBD_CYC_TWO;
        r.pc_chg = 1'b1;
      end
      8'b1110_0???: begin
        r.op = bbd_pkg::OP_CBRANCH;
        r.offset = {{8{iw[7]}}, iw[7:0]};
        r.can_skip = 1'b1;
      end
      8'b0111_????, 8'b10??_????: r.op = bbd_pkg::OP_BIT;
      8'b1111_????: begin
        r.op = bbd_pkg::OP_NOP;
        r.nop = 1'b1;
      end
      default: r.pc_chg = 1'b0;
    endcase
    // Forms without a destination bit never write back
    if (!byte_op || iw[15:12] == 4'h6 || r.op == bbd_pkg::OP_MUL) begin
      r.to_file = 1'b0;
    end
    if (r.op inside {bbd_pkg::OP_CPEQ, bbd_pkg::OP_CPGT, bbd_pkg::OP_CPLT, bbd_pkg::OP_TSTZ}) begin
      r.can_skip = 1'b1;
    end
    // Port write-back must use pin levels, not the latch
    r.rmw_pins = byte_op && r.to_file && r.faddr >= PORT_LO && r.faddr <= PORT_HI;
    r.presc_clr = byte_op && r.to_file && r.faddr == TIMER_ADDR && psa;
    return r;
  endfunction

  always_comb begin
    s_d = s_q;
    // Valid pulses once; fields hold until the next decode
    s_d.dec.vld = 1'b0;
    take = insn_valid && !s_q.hold;
    nopw = s_q.st == bbd_pkg::ST_FLUSH || cond_taken;
    w = dec_word(insn_word, s_q.bank, s_q.psa);
    if (take) begin
      s_d.last = insn_word;
      s_d.cnt = s_q.cnt + 16'h0001;
      s_d.st = bbd_pkg::ST_ONE;
      // Flushed slot is the idle second cycle of a taken test or branch
      if (nopw) begin
        s_d.dec = '0;
        s_d.dec.vld = 1'b1;
        s_d.dec.nop = 1'b1;
        s_d.dec.cycles = `BBD_CYC_ONE;
      end else if (s_q.st == bbd_pkg::ST_SECOND && insn_word[15:12] == `BBD_PFX_2ND) begin
        s_d.dec = '0;
        s_d.dec.vld = 1'b1;
        s_d.dec.op = s_q.pend;
        s_d.dec.cycles = `BBD_CYC_TWO;
        if (s_q.pend == bbd_pkg::OP_FFMOVE) begin
          s_d.dec.faddr = s_q.src;
          s_d.dec.daddr = insn_word[11:0];
        end else begin
          s_d.dec.target = {insn_word[11:0], s_q.lo};
          s_d.dec.fast = s_q.fast;
          s_d.dec.shadow = s_q.fast && s_q.pend == bbd_pkg::OP_CALL;
          s_d.dec.pc_chg = 1'b1;
        end
      end else if (w.op inside {bbd_pkg::OP_FFMOVE, bbd_pkg::OP_AJUMP, bbd_pkg::OP_CALL}) begin
        // First word alone produces no output
        s_d.st = bbd_pkg::ST_SECOND;
        s_d.pend = w.op;
        s_d.src = insn_word[11:0];
        s_d.lo = insn_word[7:0];
        s_d.fast = insn_word[8] && w.op == bbd_pkg::OP_CALL;
      end else begin
        s_d.dec = w;
        if (w.pc_chg) begin
          s_d.st = bbd_pkg::ST_FLUSH;
        end
      end
    end
    if (cond_taken && !take) begin
      s_d.st = bbd_pkg::ST_FLUSH;
    end
    // Register bus: each channel captured independently
    if (axi_req.awvalid && s_q.rsp.awready) begin
      s_d.aw_got = 1'b1;
      s_d.awa = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_q.rsp.wready) begin
      s_d.w_got = 1'b1;
      s_d.wd = axi_req.wdata;
      s_d.ws = axi_req.wstrb;
    end
    if (s_q.rsp.bvalid && axi_req.bready) begin
      s_d.rsp.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.rsp.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp = `BBD_RESP_SLVERR;
      if (s_q.awa == `BBD_REG_CTRL) begin
        s_d.rsp.bresp = `BBD_RESP_OKAY;
        if (s_q.ws[0]) begin
          s_d.hold = s_q.wd[`BBD_CTRL_HOLD];
          s_d.psa = s_q.wd[`BBD_CTRL_PSA];
        end
        if (s_q.ws[1]) begin
          s_d.bank = s_q.wd[`BBD_CTRL_BANK];
        end
      end
    end
    if (s_q.rsp.rvalid && axi_req.rready) begin
      s_d.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s_q.rsp.arready) begin
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rresp = `BBD_RESP_OKAY;
      case (axi_req.araddr)
        `BBD_REG_CTRL: s_d.rsp.rdata = {20'h00000, s_q.bank, 6'h00, s_q.psa, s_q.hold};
        `BBD_REG_STAT: s_d.rsp.rdata = {18'h00000, s_q.dec.op, 6'h00, s_q.st};
        `BBD_REG_LAST: s_d.rsp.rdata = {16'h0000, s_q.last};
        `BBD_REG_CNT:  s_d.rsp.rdata = {16'h0000, s_q.cnt};
        default: begin
          s_d.rsp.rdata = 32'h00000000;
          s_d.rsp.rresp = `BBD_RESP_SLVERR;
        end
      endcase
    end
    // Readies drop while a response waits, so one write is in flight at most
    s_d.rsp.awready = !s_d.aw_got && !s_d.rsp.bvalid;
    s_d.rsp.wready = !s_d.w_got && !s_d.rsp.bvalid;
    s_d.rsp.arready = !s_d.rsp.rvalid;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign axi_rsp = s_q.rsp;
  assign dec_o = s_q.dec;

  // Words that open a fresh decode; flushed slots and second words excluded
  logic t1;
  logic t2;
  assign t2 = insn_valid && !s_q.hold && !cond_taken;
  assign t1 = t2 && s_q.st == bbd_pkg::ST_ONE;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  AST_ADD_ROUTE: assert property (t1 && insn_word[15:10] == 6'b001001 |=>
    dec_o.vld && dec_o.op == bbd_pkg::OP_ADD && dec_o.to_file == $past(insn_word[9])
    && dec_o.flags == `BBD_FL_ALL) else $error("add decode or destination wrong");
  AST_BANK_SEL: assert property (t1 && insn_word[15:14] == 2'b10 |=>
    dec_o.faddr[11:8] == ($past(insn_word[8]) ? $past(s_q.bank) :
    (($past(insn_word[7:0]) >= ACCESS_SPLIT) ? `BBD_BANK_HI : `BBD_BANK_LO)))
    else $error("bank choice wrong");
  AST_BIT_FIELDS: assert property (t1 && insn_word[15:14] == 2'b10 |=>
    dec_o.faddr[7:0] == $past(insn_word[7:0]) && dec_o.bitpos == $past(insn_word[11:9]))
    else $error("bit fields wrong");
  AST_FFMOVE: assert property (t1 && insn_word[15:12] == `BBD_PFX_FF ##1
    t2 && insn_word[15:12] == `BBD_PFX_2ND |=> dec_o.op == bbd_pkg::OP_FFMOVE
    && dec_o.daddr == $past(insn_word[11:0]) && dec_o.faddr == $past(insn_word[11:0], 2)
    && dec_o.flags == `BBD_FL_NONE && dec_o.cycles == `BBD_CYC_TWO) else $error("move pair wrong");
  AST_JUMP_TARGET: assert property (t1 && insn_word[15:8] == `BBD_OPC_AJUMP ##1
    t2 && insn_word[15:12] == `BBD_PFX_2ND |=> dec_o.vld
    && dec_o.target == {$past(insn_word[11:0]), $past(insn_word[7:0], 2)}) else $error("jump target wrong");
  AST_CALL_SHADOW: assert property (t1 && insn_word[15:9] == 7'b1110110 ##1
    t2 && insn_word[15:12] == `BBD_PFX_2ND |=> dec_o.op == bbd_pkg::OP_CALL
    && dec_o.shadow == $past(insn_word[8], 2)) else $error("shadow select wrong");
  AST_UBR_OFFSET: assert property (t1 && insn_word[15:11] == 5'b11010 |=>
    dec_o.offset == {{5{$past(insn_word[10])}}, $past(insn_word[10:0])}
    && s_q.st == bbd_pkg::ST_FLUSH) else $error("branch offset wrong");
  AST_FLUSH_NOP: assert property ((s_q.st == bbd_pkg::ST_FLUSH || cond_taken)
    && insn_valid && !s_q.hold |=> dec_o.vld && dec_o.nop) else $error("no-op slot missed");
  AST_ORPHAN: assert property (t1 && insn_word[15:12] == `BBD_PFX_2ND |=>
    dec_o.vld && dec_o.nop) else $error("orphan second word executed");
  AST_PRESC: assert property (dec_o.vld && dec_o.presc_clr |-> dec_o.to_file
    && dec_o.faddr == TIMER_ADDR && $past(s_q.psa)) else $error("prescaler clear wrong");

  // Skip forms leave the flags alone; the datapath decides the extra slot
  AST_CMP_SKIP: assert property (t1 && insn_word[15:11] == 5'b01100 |=>
    dec_o.vld && dec_o.can_skip && !dec_o.to_file && dec_o.flags == `BBD_FL_NONE)
    else $error("compare skip decode wrong");
  AST_NZ_SKIP: assert property (t1 && insn_word[15:11] == 5'b01001 |=>
    dec_o.can_skip && dec_o.flags == `BBD_FL_NONE && dec_o.cycles == `BBD_CYC_ONE
    && dec_o.to_file == $past(insn_word[9])) else $error("nonzero skip decode wrong");
  AST_MUL_FLAGS: assert property (t1 && insn_word[15:9] == 7'b0000001 |=>
    dec_o.op == bbd_pkg::OP_MUL && dec_o.flags == `BBD_FL_NONE && dec_o.cycles == `BBD_CYC_ONE)
    else $error("multiply decode wrong");
  AST_ROT_FLAGS: assert property (t1 && insn_word[15:11] == 5'b00110 |=>
    dec_o.flags == `BBD_FL_CZN && dec_o.to_file == $past(insn_word[9]))
    else $error("carry rotate flags wrong");
  AST_SUB_FLAGS: assert property (t1 && insn_word[15:12] == 4'h5 && insn_word[11:10] != 2'b00 |=>
    dec_o.flags == `BBD_FL_ALL && dec_o.to_file == $past(insn_word[9]))
    else $error("subtract decode wrong");
  AST_CBR_OFFSET: assert property (t1 && insn_word[15:11] == 5'b11100 |=>
    dec_o.offset == {{8{$past(insn_word[7])}}, $past(insn_word[7:0])} && dec_o.can_skip)
    else $error("conditional branch offset wrong");
  AST_LIT_IMM: assert property (t1 && insn_word[15:12] == 4'h0 |=>
    dec_o.vld && dec_o.imm == $past(insn_word[7:0])) else $error("literal byte wrong");

  COV_FFMOVE: cover property (dec_o.vld && dec_o.op == bbd_pkg::OP_FFMOVE);
  COV_SKIP: cover property (dec_o.can_skip && cond_taken ##1 dec_o.vld && dec_o.nop);
  COV_HOLD: cover property (insn_valid && s_q.hold);
  COV_ORPHAN: cover property (t1 && insn_word[15:12] == `BBD_PFX_2ND);
  COV_WRITE: cover property (s_q.rsp.bvalid && axi_req.bready);

endmodule

// >>> bench/bbd_fetch_model.sv
`timescale 1ns/1ps
module bbd_fetch_model (
  input  wire logic        sys_clk,
  output logic             insn_valid,
  output logic [15:0]      insn_word,
  output logic             cond_taken
);
  initial begin
    insn_valid = 1'b0;
    insn_word  = 16'h0000;
    cond_taken = 1'b0;
  end
  // One word per call; back to back calls give back to back words
  task automatic offer(input logic [15:0] w, input logic c);
    @(posedge sys_clk);
    insn_valid <= 1'b1;
    insn_word  <= w;
    cond_taken <= c;
  endtask
  // Inverted word so a stale copy never passes for a fresh one
  task automatic idle();
    @(posedge sys_clk);
    insn_valid <= 1'b0;
    insn_word  <= ~insn_word;
    cond_taken <= 1'b0;
  endtask
endmodule

// >>> bench/byte_bit_ctrl_insn_decoder_tb.sv
`timescale 1ns/1ps
`include "bbd_defs.svh"
module byte_bit_ctrl_insn_decoder_tb;
  typedef struct packed {
    logic [7:0]       opc;
    bbd_pkg::bbd_op_t op;
    logic [4:0]       fl;
    logic             hasd;
    logic             skp;
  } bbd_case_t;
  localparam bbd_case_t TBL [25] = '{
    '{8'h24, bbd_pkg::OP_ADD, 5'h1f, 1'b1, 1'b0}, '{8'h20, bbd_pkg::OP_ADDC, 5'h1f, 1'b1, 1'b0},
    '{8'h14, bbd_pkg::OP_AND, 5'h14, 1'b1, 1'b0}, '{8'h10, bbd_pkg::OP_OR, 5'h14, 1'b1, 1'b0},
    '{8'h18, bbd_pkg::OP_XOR, 5'h14, 1'b1, 1'b0}, '{8'h1c, bbd_pkg::OP_COM, 5'h14, 1'b1, 1'b0},
    '{8'h04, bbd_pkg::OP_DEC, 5'h1f, 1'b1, 1'b0}, '{8'h28, bbd_pkg::OP_INC, 5'h1f, 1'b1, 1'b0},
    '{8'h2c, bbd_pkg::OP_DECSZ, 5'h00, 1'b1, 1'b1}, '{8'h3c, bbd_pkg::OP_INCSZ, 5'h00, 1'b1, 1'b1},
    '{8'h4c, bbd_pkg::OP_DECSNZ, 5'h00, 1'b1, 1'b1}, '{8'h48, bbd_pkg::OP_INCSNZ, 5'h00, 1'b1, 1'b1},
    '{8'h62, bbd_pkg::OP_CPEQ, 5'h00, 1'b0, 1'b1}, '{8'h64, bbd_pkg::OP_CPGT, 5'h00, 1'b0, 1'b1},
    '{8'h60, bbd_pkg::OP_CPLT, 5'h00, 1'b0, 1'b1}, '{8'h66, bbd_pkg::OP_TSTZ, 5'h00, 1'b0, 1'b1},
    '{8'h34, bbd_pkg::OP_RLC, 5'h15, 1'b1, 1'b0}, '{8'h30, bbd_pkg::OP_RRC, 5'h15, 1'b1, 1'b0},
    '{8'h44, bbd_pkg::OP_RL, 5'h14, 1'b1, 1'b0}, '{8'h40, bbd_pkg::OP_RR, 5'h14, 1'b1, 1'b0},
    '{8'h50, bbd_pkg::OP_MOVE, 5'h14, 1'b1, 1'b0}, '{8'h5c, bbd_pkg::OP_SUB, 5'h1f, 1'b1, 1'b0},
    '{8'h58, bbd_pkg::OP_SUBB, 5'h1f, 1'b1, 1'b0}, '{8'h54, bbd_pkg::OP_SUBFB, 5'h1f, 1'b1, 1'b0},
    '{8'h02, bbd_pkg::OP_MUL, 5'h00, 1'b0, 1'b0}};
  logic                  sys_clk;
  logic                  rst_b;
  logic                  insn_valid;
  logic [15:0]           insn_word;
  logic                  cond_taken;
  bbd_pkg::bbd_axi_req_t req;
  bbd_pkg::bbd_axi_rsp_t rsp;
  bbd_pkg::bbd_dec_t     dec;
  int                    err_count;
  int                    num_checks;
  logic [31:0]           rd;
  logic [1:0]            rr;

  bbd_fetch_model u_bbd_fetch_model (
    .sys_clk   (sys_clk),
    .insn_valid(insn_valid),
    .insn_word (insn_word),
    .cond_taken(cond_taken)
  );
  bbd_decoder u_bbd_decoder (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .insn_valid(insn_valid),
    .insn_word (insn_word),
    .cond_taken(cond_taken),
    .axi_req   (req),
    .axi_rsp   (rsp),
    .dec_o     (dec)
  );

  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Ready is looked at mid-cycle, where it equals its value at the next edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    r = 2'h3;
    do begin
      @(negedge sys_clk);
      aw_ok = req.awvalid && rsp.awready;
      w_ok  = req.wvalid && rsp.wready;
      b_ok  = rsp.bvalid;
      if (b_ok) r = rsp.bresp;
      @(posedge sys_clk);
      if (aw_ok) req.awvalid <= 1'b0;
      if (w_ok) req.wvalid <= 1'b0;
      if (b_ok) req.bready <= 1'b0;
    end while (!b_ok);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok;
    logic r_ok;
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    r = 2'h3;
    d = 32'hdead_beef;
    do begin
      @(negedge sys_clk);
      ar_ok = req.arvalid && rsp.arready;
      r_ok  = rsp.rvalid;
      if (r_ok) begin
        r = rsp.rresp;
        d = rsp.rdata;
      end
      @(posedge sys_clk);
      if (ar_ok) req.arvalid <= 1'b0;
      if (r_ok) req.rready <= 1'b0;
    end while (!r_ok);
  endtask

  task automatic run(input logic [15:0] w0, input logic [15:0] w1, input logic two);
    u_bbd_fetch_model.offer(w0, 1'b0);
    if (two) begin
      u_bbd_fetch_model.offer(w1, 1'b0);
      @(negedge sys_clk);
      chk(32'(dec.vld), 32'h0);
    end
    u_bbd_fetch_model.idle();
    @(negedge sys_clk);
    chk(32'(dec.vld), 32'h1);
  endtask

  task automatic t_regs();
    axi_rd(`BBD_REG_CTRL, rd, rr);
    chk(rd, 32'h0);
    axi_wr(`BBD_REG_CTRL, 32'h0000_0500, rr);
    chk(32'(rr), 32'(`BBD_RESP_OKAY));
    axi_wr(`BBD_REG_STAT, 32'h0000_0f03, rr);
    chk(32'(rr), 32'(`BBD_RESP_SLVERR));
    axi_rd(8'h10, rd, rr);
    chk({rd[29:0], rr}, {30'h0, `BBD_RESP_SLVERR});
    axi_rd(`BBD_REG_CTRL, rd, rr);
    chk(rd, 32'h0000_0500);
  endtask

  task automatic t_byte_ops();
    bbd_case_t   c;
    logic [7:0]  f;
    logic        a;
    logic        d;
    logic [11:0] ea;
    for (int i = 0; i < 50; i++) begin
      c = TBL[i / 2];
      f = 8'(i * 37);
      a = i[0];
      d = ~i[0] & c.hasd;
      ea = a ? {4'h5, f} : {(f < 8'h80) ? 4'h0 : 4'hf, f};
      run({c.opc | {6'h00, d, a}, f}, 16'h0000, 1'b0);
      chk(32'(dec.op), 32'(c.op));
      chk(32'(dec.to_file), 32'(d));
      chk(32'(dec.use_bank), 32'(a));
      chk(32'(dec.faddr), 32'(ea));
      chk(32'(dec.flags), 32'(c.fl));
      chk({30'h0, dec.cycles}, 32'(`BBD_CYC_ONE));
      chk({31'h0, dec.can_skip}, 32'(c.skp));
    end
  endtask

  task automatic t_side();
    run(16'h5285, 16'h0000, 1'b0);
    chk(32'(dec.rmw_pins), 32'h1);
    run(16'h5085, 16'h0000, 1'b0);
    chk(32'(dec.rmw_pins), 32'h0);
    axi_wr(`BBD_REG_CTRL, 32'h0000_0502, rr);
    run(16'h26c0, 16'h0000, 1'b0);
    chk(32'(dec.presc_clr), 32'h1);
    axi_wr(`BBD_REG_CTRL, 32'h0000_0501, rr);
    u_bbd_fetch_model.offer(16'h2603, 1'b0);
    u_bbd_fetch_model.idle();
    @(negedge sys_clk);
    chk(32'(dec.vld), 32'h0);
    axi_rd(`BBD_REG_LAST, rd, rr);
    chk(rd, 32'h0000_26c0);
    axi_rd(`BBD_REG_CNT, rd, rr);
    chk(rd, 32'h0000_0035);
    axi_rd(`BBD_REG_STAT, rd, rr);
    chk(rd, {18'h0, bbd_pkg::OP_ADD, 8'h00});
    axi_wr(`BBD_REG_CTRL, 32'h0000_0500, rr);
    run(16'h26c0, 16'h0000, 1'b0);
    chk(32'(dec.presc_clr), 32'h0);
  endtask

  task automatic t_ctrl();
    run(16'hc123, 16'hf456, 1'b1);
    chk({2'h0, dec.op, dec.faddr, dec.daddr}, {2'h0, bbd_pkg::OP_FFMOVE, 12'h123, 12'h456});
    chk({25'h0, dec.flags, dec.cycles}, {30'h0, `BBD_CYC_TWO});
    run(16'hef34, 16'hf567, 1'b1);
    chk({6'h0, dec.op, dec.target}, {6'h0, bbd_pkg::OP_AJUMP, 20'h56734});
    run(16'hed12, 16'hfabc, 1'b1);
    chk({dec.target, dec.fast, dec.shadow}, {20'habc12, 2'b11});
    run(16'hec12, 16'hfabc, 1'b1);
    chk({dec.target, dec.fast, dec.shadow}, {20'habc12, 2'b00});
    run(16'he285, 16'h0000, 1'b0);
    chk({dec.op, dec.offset}, {bbd_pkg::OP_CBRANCH, 16'hff85});
    run(16'h9a33, 16'h0000, 1'b0);
    chk({dec.op, dec.bitpos, dec.use_bank}, {bbd_pkg::OP_BIT, 3'h5, 1'b0});
    run(16'h0f7f, 16'h0000, 1'b0);
    chk(32'(dec.imm), 32'h7f);
    run(16'hf123, 16'h0000, 1'b0);
    chk(32'(dec.nop), 32'h1);
    run(16'hd401, 16'h0000, 1'b0);
    chk({dec.op, dec.offset, dec.pc_chg}, {bbd_pkg::OP_UBRANCH, 16'hfc01, 1'b1});
    run(16'h2603, 16'h0000, 1'b0);
    chk(32'(dec.nop), 32'h1);
  endtask

  // Skip decided by the datapath in the same cycle as the next word
  task automatic t_skip();
    u_bbd_fetch_model.offer(16'h2e05, 1'b0);
    u_bbd_fetch_model.offer(16'h2603, 1'b1);
    u_bbd_fetch_model.idle();
    @(negedge sys_clk);
    chk({dec.vld, dec.nop}, 2'b11);
    run(16'h2603, 16'h0000, 1'b0);
    chk({dec.nop, dec.op, dec.faddr}, {1'b0, bbd_pkg::OP_ADD, 12'h003});
  endtask

  initial begin
    rst_b = 1'b0;
    req = '0;
    err_count = 0;
    num_checks = 0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_byte_ops();
    t_side();
    t_ctrl();
    t_skip();
    tally_and_finish();
  end

  initial begin
    #2000000;
    err_count++;
    tally_and_finish();
  end
endmodule
